// ---- core/bit_test_decode.sv ----
module bit_test_decode (
  // Instruction word
  input wire logic [bit_test_pkg::instr_width-1:0] instr_in,
  // Decoded fields
  output bit_test_pkg::decoded_type decoded_out
);

  always_comb begin
    decoded_out.sel = instr_in[bit_test_pkg::sel_msb:bit_test_pkg::sel_lsb];
    decoded_out.addr = instr_in[bit_test_pkg::addr_msb:bit_test_pkg::addr_lsb];
    case (instr_in[bit_test_pkg::opcode_msb:bit_test_pkg::opcode_lsb])
      bit_test_pkg::opcode_skip_clear: begin
        decoded_out.op = bit_test_pkg::op_skip_clear; // [RL6]
      end
      bit_test_pkg::opcode_skip_set: begin
        decoded_out.op = bit_test_pkg::op_skip_set; // [RL2]
      end
      default: begin
        decoded_out.op = bit_test_pkg::op_none;
      end
    endcase
  end

endmodule : bit_test_decode

// ---- core/bit_test_pkg.sv ----
package bit_test_pkg;

  localparam int instr_width = 12;
  localparam int addr_width = 5;
  localparam int sel_width = 3;
  localparam int data_width = 8;

  // Opcode field sits in the top four bits of the instruction word.
  localparam int opcode_msb = 11;
  localparam int opcode_lsb = 8;
  localparam int sel_msb = 7;
  localparam int sel_lsb = 5;
  localparam int addr_msb = 4;
  localparam int addr_lsb = 0;

  localparam logic [3:0] opcode_skip_clear = 4'h6;
  localparam logic [3:0] opcode_skip_set = 4'h7;

  // All-zero word is the no-operation of this core.
  localparam logic [instr_width-1:0] no_operation_word = 12'h000;
  localparam logic [addr_width-1:0] addr_reset = 5'h00;

  typedef enum logic [2:0] {
    op_none = 3'b001,
    op_skip_clear = 3'b010,
    op_skip_set = 3'b100
  } test_op_type;

  typedef struct packed {
    test_op_type op;
    logic [sel_width-1:0] sel;
    logic [addr_width-1:0] addr;
  } decoded_type;

endpackage : bit_test_pkg

// ---- core/bit_test_skip_decode.sv ----
// Behaviour
// RL1: The skip-if-clear test skips the next instruction when the selected register bit is zero.
// RL2: Word 0111 bbbf ffff is the skip-if-set test, skipping when the selected bit is one.
// RL3: A taken skip discards the prefetched word and executes a no-operation in its place.
// RL4: A bit test takes one cycle without skip and two cycles with the skip taken.
// RL5: Fetch runs in parallel with the test; the skip cancels a fetched word, never stalls fetch.
// RL6: Word 0110 bbbf ffff is the skip-if-clear test; neither test writes flags or the register.
module bit_test_skip_decode (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Instruction from fetch, one word per instruction cycle
  input wire logic [bit_test_pkg::instr_width-1:0] fetch_word_in,
  input wire logic fetch_valid_in,
  // Register file read port, combinational answer to read_addr_out
  input wire logic [bit_test_pkg::data_width-1:0] file_data_in,
  // Register file address for the test in execute
  output logic [bit_test_pkg::addr_width-1:0] read_addr_out,
  // Execute stage
  output logic [bit_test_pkg::instr_width-1:0] exec_word_out,
  output logic exec_valid_out,
  output logic exec_flush_out,
  output logic skip_taken_out,
  output logic pass_on_out
);

  ////////////////////////////////////////////////////////////////////////////
  // The execute slot is open for a test, or held for one cycle as the
  // no-operation that replaces a discarded prefetch.
  typedef enum logic [1:0] {
    slot_open = 2'h1,
    slot_flush = 2'h2
  } slot_state_type;

  logic [bit_test_pkg::instr_width-1:0] exec_word_q;
  logic exec_valid_q;
  slot_state_type slot_q;
  slot_state_type slot_d;
  logic skip_taken_q;
  logic pass_on_q;
  logic [bit_test_pkg::addr_width-1:0] read_addr_q;

  bit_test_pkg::decoded_type dec;
  logic [bit_test_pkg::data_width-1:0] sel_onehot;
  logic [bit_test_pkg::data_width-1:0] bit_hit;
  logic bit_value;
  logic skip_d;

  bit_test_decode decoder (
    .instr_in(exec_word_q),
    .decoded_out(dec)
  );

  // The read port is addressed from the word now in execute, so the tested bit
  // is ready in the same instruction cycle as the test itself.
  // Each bit is gated by its own select line; an AND-OR keeps the pick flat
  // and avoids a variable index into the byte.
  for (genvar b = 0; b < bit_test_pkg::data_width; b++) begin : g_bit
    assign sel_onehot[b] = (int'(dec.sel) == b);
    assign bit_hit[b] = sel_onehot[b] & file_data_in[b];
  end

  assign bit_value = |bit_hit; // [RL1] [RL2]

  // A flushed slot never tests, so a bit test that was itself skipped has no effect.
  always_comb begin
    skip_d = 1'b0;
    if (exec_valid_q && (slot_q == slot_open)) begin
      case (dec.op)
        bit_test_pkg::op_skip_clear: begin
          skip_d = (bit_value == 1'b0); // [RL1]
        end
        bit_test_pkg::op_skip_set: begin
          skip_d = (bit_value == 1'b1); // [RL2]
        end
        default: begin
          skip_d = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fetch is never held back: the next word is always accepted, even in the
  // cycle in which it is about to be discarded. [RL5]
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      exec_word_q <= bit_test_pkg::no_operation_word;
    end else if (fetch_valid_in) begin
      exec_word_q <= fetch_word_in; // [RL5]
    end else begin
      exec_word_q <= bit_test_pkg::no_operation_word;
    end
  end

  // An empty fetch slot leaves execute idle, and an idle slot never tests.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      exec_valid_q <= 1'b0;
    end else begin
      exec_valid_q <= fetch_valid_in;
    end
  end

  // The flush holds the prefetched word as a no-operation for one cycle,
  // which is the second cycle of the taken test. [RL3] [RL4]
  always_comb begin
    slot_d = slot_q;
    case (slot_q)
      slot_open: begin
        if (skip_d) begin
          slot_d = slot_flush; // [RL3]
        end else begin
          slot_d = slot_open;
        end
      end
      slot_flush: begin
        slot_d = slot_open; // [RL4]
      end
      default: begin
        slot_d = slot_open;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      slot_q <= slot_open;
    end else begin
      slot_q <= slot_d;
    end
  end

  // One pulse per taken skip, so the core can account for the extra cycle
  // without decoding the flushed slot itself. [RL4]
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      skip_taken_q <= 1'b0;
    end else begin
      skip_taken_q <= skip_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tests only read the file; pass_on tells the core the executing slot is a
  // real instruction. Flag and register writes stay with the core. [RL6]
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pass_on_q <= 1'b0;
    end else begin
      pass_on_q <= fetch_valid_in && !skip_d;
    end
  end

  // The address follows every fetched word, valid or not; an empty slot
  // decodes as a no-operation, so a stale address is never tested.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      read_addr_q <= bit_test_pkg::addr_reset;
    end else begin
      read_addr_q <= fetch_word_in[bit_test_pkg::addr_msb:bit_test_pkg::addr_lsb];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The word sent on is replaced by a no-operation while it is flushed, and an
  // empty fetch slot is sent on as a no-operation as well. [RL3]
  logic [bit_test_pkg::instr_width-1:0] out_word_d;
  logic [bit_test_pkg::instr_width-1:0] out_word_q;
  logic out_valid_q;
  logic out_flush_q;

  always_comb begin
    out_word_d = bit_test_pkg::no_operation_word;
    case ({skip_d, fetch_valid_in})
      2'h1: begin
        out_word_d = fetch_word_in;
      end
      2'h3: begin
        out_word_d = bit_test_pkg::no_operation_word; // [RL3]
      end
      default: begin
        out_word_d = bit_test_pkg::no_operation_word;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      out_word_q <= bit_test_pkg::no_operation_word;
    end else begin
      out_word_q <= out_word_d;
    end
  end

  // Valid follows fetch even in a flushed slot: the slot was filled, its word
  // was only discarded. [RL5]
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      out_valid_q <= 1'b0;
    end else begin
      out_valid_q <= fetch_valid_in;
    end
  end

  // The flush pulse marks the slot that holds the inserted no-operation.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      out_flush_q <= 1'b0;
    end else begin
      out_flush_q <= skip_d; // [RL3]
    end
  end

  assign read_addr_out = read_addr_q;
  assign exec_word_out = out_word_q;
  assign exec_valid_out = out_valid_q;
  assign exec_flush_out = out_flush_q;
  assign skip_taken_out = skip_taken_q;
  assign pass_on_out = pass_on_q;

endmodule : bit_test_skip_decode

// ---- testbench/bit_test_skip_decode_tb.sv ----
module bit_test_skip_decode_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
  logic clk_in = 1'b0, sys_rst_in = 1'b1, fetch_valid_in = 1'b0;
  logic [11:0] fetch_word_in = 12'h000, exec_word_out;
  logic [7:0] file_data_in;
  logic [4:0] read_addr_out;
  logic exec_valid_out, exec_flush_out, skip_taken_out, pass_on_out;
  int mismatches = 0, total_checks = 0;
  always #2 clk_in = ~clk_in;
  bit_test_skip_decode dut (.clk_in, .sys_rst_in, .fetch_word_in, .fetch_valid_in,
    .file_data_in, .read_addr_out, .exec_word_out, .exec_valid_out, .exec_flush_out,
    .skip_taken_out, .pass_on_out);
  file_model u_file (.addr_in(read_addr_out), .data_out(file_data_in));
  //////////////////////////////////////////////////////////////////////////////
  task step(input logic [11:0] w, input logic v);
    @(negedge clk_in);
    fetch_word_in = w;
    fetch_valid_in = v;
  endtask : step
  task t_one(input logic [3:0] op, input logic [2:0] b, input logic [4:0] f);
    logic [7:0] d;
    logic sk;
    d = {f, f[2:0]};
    sk = (d[b] == op[0]);
    step({op, b, f}, 1'b1);
    step(12'ha5a, 1'b1);
    `CHK("test word", {op, b, f}, exec_word_out)
    `CHK("addr", f, read_addr_out)
    step(12'h000, 1'b0);
    `CHK("word", sk ? 12'h000 : 12'ha5a, exec_word_out)
    `CHK("valid", 1'b1, exec_valid_out)
    `CHK("flush", sk, exec_flush_out)
    `CHK("skip", sk, skip_taken_out)
    `CHK("pass", !sk, pass_on_out)
  endtask : t_one
  // A test word in a flushed slot must not skip the word after it.
  task t_chain;
    step(12'h600, 1'b1);
    step(12'h600, 1'b1);
    step(12'ha5a, 1'b1);
    `CHK("chain first", 1'b1, exec_flush_out)
    step(12'h000, 1'b0);
    `CHK("chain word", 12'ha5a, exec_word_out)
    `CHK("chain flush", 1'b0, exec_flush_out)
  endtask : t_chain
  // An empty fetch slot holding a test opcode must stay an idle no-operation.
  task t_idle;
    step(12'h7ff, 1'b0);
    step(12'h000, 1'b0);
    `CHK("idle word", 12'h000, exec_word_out)
    `CHK("idle valid", 1'b0, exec_valid_out)
    `CHK("idle pass", 1'b0, pass_on_out)
    step(12'h000, 1'b0);
    `CHK("idle flush", 1'b0, exec_flush_out)
  endtask : t_idle
  // A reset in the middle of a taken skip must leave no flush behind.
  task t_reset;
    step(12'h600, 1'b1);
    step(12'ha5a, 1'b1);
    sys_rst_in = 1'b1;
    step(12'h000, 1'b0);
    sys_rst_in = 1'b0;
    `CHK("reset word", 12'h000, exec_word_out)
    `CHK("reset flush", 1'b0, exec_flush_out)
    step(12'h000, 1'b0);
    `CHK("reset skip", 1'b0, skip_taken_out)
  endtask : t_reset
  task end_of_test;
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (2) @(negedge clk_in);
    sys_rst_in = 1'b0;
    for (int i = 0; i < 64; i++) begin
      t_one({3'h3, i[0]}, i[3:1], 5'(i * 7));
    end
    t_chain();
    t_idle();
    t_reset();
    end_of_test();
  end
endmodule : bit_test_skip_decode_tb

// ---- testbench/bts_checker.sv ----
module bts_checker (
  // Watched ports
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [11:0] fetch_word_in,
  input wire logic fetch_valid_in,
  input wire logic [7:0] file_data_in,
  input wire logic [4:0] read_addr_out,
  input wire logic [11:0] exec_word_out,
  input wire logic exec_valid_out,
  input wire logic exec_flush_out,
  input wire logic skip_taken_out,
  input wire logic pass_on_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  logic hit;
  // Opcodes 6 and 7 differ only in bit 8, which is the bit value that skips.
  assign hit = pass_on_out && exec_word_out[11:9] == 3'h3
    && file_data_in[exec_word_out[7:5]] == exec_word_out[8];
  sequence s_nop;
    exec_flush_out && skip_taken_out && exec_word_out == 12'h000 && !pass_on_out;
  endsequence
  property p_skip; hit |=> s_nop; endproperty
  a_skip: assert property (p_skip) else $error("skip not taken");
  property p_flow;
    !hit && fetch_valid_in |=> exec_word_out == $past(fetch_word_in) && pass_on_out
      && exec_valid_out && !exec_flush_out;
  endproperty
  a_flow: assert property (p_flow) else $error("fetched word lost");
  property p_once; exec_flush_out |=> !exec_flush_out; endproperty
  a_once: assert property (p_once) else $error("flush too long");
  property p_addr; pass_on_out |-> read_addr_out == exec_word_out[4:0]; endproperty
  a_addr: assert property (p_addr) else $error("wrong file address");
  property p_other; pass_on_out && exec_word_out[11:9] != 3'h3 |=> !exec_flush_out; endproperty
  a_other: assert property (p_other) else $error("skip on other word");
  property p_idle;
    !fetch_valid_in |=> !exec_valid_out && !pass_on_out && exec_word_out == 12'h000;
  endproperty
  a_idle: assert property (p_idle) else $error("empty slot not idle");
endmodule : bts_checker

bind bit_test_skip_decode bts_checker u_chk (.clk_in, .sys_rst_in, .fetch_word_in,
  .fetch_valid_in, .file_data_in, .read_addr_out, .exec_word_out, .exec_valid_out,
  .exec_flush_out, .skip_taken_out, .pass_on_out);

// ---- testbench/file_model.sv ----
module file_model (
  // Read port
  input wire logic [4:0] addr_in,
  output logic [7:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Contents follow the address, so every byte is known without a load phase.
  assign data_out = {addr_in, addr_in[2:0]};
endmodule : file_model
